// >>> dc_brake_sequencer_tb.sv
// Directed testbench of the brake sequencer
`timescale 1ns/1ps
`default_nettype none
module dc_brake_sequencer_tb;
    logic        mclk, rst, regWr, regRd, runReq;
    logic [3:0]  regAddr;
    logic [15:0] regWdata, regRdata, freqReq, freqCommand, outputFreq;
    logic [4:0]  termReq, inputTerminals;
    logic        forwardRunCommand, outputCut, brakeActive;
    logic        carrierBrakeSel, motorSetSecond;
    logic [7:0]  brakeCurrent, carrierKhz;
    int          n_errors, tests_run, cnt, t0;
    logic [15:0] rstVal [0:10] = '{16'h0000, 16'h0032, 16'h0000, 16'h0000,
        16'h0005, 16'h0000, 16'h0005, 16'h0005, 16'h0000, 16'h0001, 16'h0000};

    dcbs_sequencer #(.TICK_CYC(10)) u_dut (.mclk(mclk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .inputTerminals(inputTerminals),
        .forwardRunCommand(forwardRunCommand), .freqCommand(freqCommand),
        .outputFreq(outputFreq), .brakeCurrent(brakeCurrent),
        .outputCut(outputCut), .brakeActive(brakeActive),
        .carrierKhz(carrierKhz), .carrierBrakeSel(carrierBrakeSel),
        .motorSetSecond(motorSetSecond));
    dcbs_ctrl_model u_ctrl (.mclk(mclk), .rst(rst), .runReq(runReq),
        .freqReq(freqReq), .termReq(termReq),
        .forwardRunCommand(forwardRunCommand), .freqCommand(freqCommand),
        .outputFreq(outputFreq), .inputTerminals(inputTerminals));

    // Clock of 40 ns period
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic complete_run;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Strobes rise one edge after entry so no two calls collide
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, exp);
    endtask

    task automatic setIn(input logic r, input logic [15:0] f,
                         input logic [4:0] t);
        @(posedge mclk);
        runReq  <= r;
        freqReq <= f;
        termReq <= t;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Bounded wait on the brake flag; cnt keeps the cycles spent
    task automatic waitBrk(input logic v, input int n);
        cnt = 0;
        while (brakeActive !== v && cnt < n) begin
            cyc(1);
            cnt++;
        end
        chk(brakeActive, v);
    endtask

    // Run at 10 Hz, then stop and wait for the brake to engage
    task automatic stopCycle(input int n);
        setIn(1'b1, 16'h03E8, 5'h00);
        cyc(25);
        setIn(1'b0, 16'h03E8, 5'h00);
        waitBrk(1'b1, n);
    endtask

    initial begin
        cyc(20000);
        n_errors++;
        complete_run();
    end

    initial begin
        rst = 1'b1;
        {regWr, regRd, runReq, regAddr, regWdata, freqReq, termReq} = '0;
        n_errors = 0;
        tests_run = 0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        cyc(1);
        chk(outputCut, 1'b1);
        chk(carrierKhz, 16'h0005);
        chk(brakeActive, 1'b0);
        for (int i = 0; i <= 10; i++)
            rd(i[3:0], rstVal[i]); // 9 status in stop, 10 unmapped
        // Clamping of settings to their ranges
        wr(4'h1, 16'hFFFF);
        rd(4'h1, 16'h1770);
        wr(4'h2, 16'h00FF);
        rd(4'h2, 16'h0032);
        wr(4'h3, 16'h00FF);
        rd(4'h3, 16'h0064);
        wr(4'h4, 16'h00FF);
        rd(4'h4, 16'h0064);
        wr(4'h7, 16'h0020);
        rd(4'h7, 16'h000F);
        wr(4'h7, 16'h0000);
        rd(4'h7, 16'h0002);
        wr(4'h0, 16'h0003);
        rd(4'h0, 16'h0000);
        // Motor set follows the terminal only while stopped
        wr(4'h8, 16'h0008);
        setIn(1'b0, 16'h0000, 5'h04);
        cyc(4);
        chk(motorSetSecond, 1'b1);
        setIn(1'b1, 16'h03E8, 5'h04);
        cyc(25);
        setIn(1'b1, 16'h03E8, 5'h00);
        cyc(4);
        chk(motorSetSecond, 1'b1);
        setIn(1'b0, 16'h0000, 5'h00);
        cyc(30);
        chk(motorSetSecond, 1'b0);
        // Internal edge braking, no wait: 0.5 Hz, 50 %, 0.3 s, 9 kHz
        wr(4'h8, 16'h0000);
        wr(4'h1, 16'h0032);
        wr(4'h3, 16'h0032);
        wr(4'h4, 16'h0003);
        wr(4'h5, 16'h0064);
        wr(4'h6, 16'h0000);
        wr(4'h7, 16'h0009);
        wr(4'h2, 16'h0000);
        wr(4'h0, 16'h0001);
        stopCycle(40);
        t0 = cnt;
        chk(brakeCurrent, 16'h0032 * 16'h00FF / 16'h0064);
        chk(carrierKhz, 16'h0009);
        waitBrk(1'b0, 60);
        chk(cnt >= 29 && cnt <= 32, 1'b1);
        // Edge mode: a start command cannot cut the brake short
        stopCycle(40);
        cyc(5);
        setIn(1'b1, 16'h03E8, 5'h00);
        cyc(5);
        chk(brakeActive, 1'b1);
        waitBrk(1'b0, 40);
        chk(cnt >= 14, 1'b1);
        cyc(25);
        // Nonzero wait delays injection by the coast interval
        wr(4'h2, 16'h0002);
        stopCycle(80);
        chk(cnt >= t0 + 19, 1'b1);
        waitBrk(1'b0, 60);
        wr(4'h2, 16'h0000);
        // Level mode: a start command ends braking at once
        wr(4'h0, 16'h0005);
        stopCycle(40);
        cyc(3);
        setIn(1'b1, 16'h03E8, 5'h00);
        cyc(3);
        chk(brakeActive, 1'b0);
        // Start braking at full starting force for 0.2 s
        setIn(1'b0, 16'h03E8, 5'h00);
        waitBrk(1'b1, 40);
        waitBrk(1'b0, 60);
        wr(4'h6, 16'h0002);
        setIn(1'b1, 16'h03E8, 5'h00);
        waitBrk(1'b1, 5);
        chk(brakeCurrent, 16'h00FF);
        waitBrk(1'b0, 40);
        chk(cnt >= 18 && cnt <= 22, 1'b1);
        wr(4'h6, 16'h0000);
        setIn(1'b0, 16'h03E8, 5'h00);
        waitBrk(1'b1, 40);
        waitBrk(1'b0, 60);
        // External brake terminal, level then edge, decel force 25 %
        wr(4'h0, 16'h0004);
        wr(4'h8, 16'h0007);
        wr(4'h3, 16'h0019);
        setIn(1'b0, 16'h0000, 5'h01);
        waitBrk(1'b1, 4);
        chk(brakeCurrent, 16'h003F);
        cyc(60);
        chk(brakeActive, 1'b1);
        setIn(1'b0, 16'h0000, 5'h00);
        waitBrk(1'b0, 4);
        wr(4'h0, 16'h0000);
        setIn(1'b0, 16'h0000, 5'h01);
        cyc(2);
        setIn(1'b0, 16'h0000, 5'h00);
        waitBrk(1'b1, 4);
        waitBrk(1'b0, 60);
        chk(cnt >= 27 && cnt <= 32, 1'b1);
        // Frequency-triggered braking with 2 Hz hysteresis
        wr(4'h8, 16'h0000);
        wr(4'h0, 16'h0002);
        setIn(1'b1, 16'h03E8, 5'h00);
        cyc(25);
        chk(brakeActive, 1'b0);
        setIn(1'b1, 16'h0014, 5'h00);
        waitBrk(1'b1, 40);
        setIn(1'b1, 16'h00F9, 5'h00);
        cyc(4);
        chk(brakeActive, 1'b1);
        setIn(1'b1, 16'h00FA, 5'h00);
        waitBrk(1'b0, 4);
        setIn(1'b0, 16'h0000, 5'h00);
        cyc(30);
        chk(brakeActive, 1'b0);
        complete_run();
    end
endmodule // dc_brake_sequencer_tb
`default_nettype wire

// >>> dcbs_ctrl_model.sv
// Behavioural model of the controller on run, frequency and terminal pins
`timescale 1ns/1ps
`default_nettype none
module dcbs_ctrl_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        runReq,
    input  wire logic [15:0] freqReq,
    input  wire logic [4:0]  termReq,
    output var  logic        forwardRunCommand,
    output var  logic [15:0] freqCommand,
    output var  logic [15:0] outputFreq,
    output var  logic [4:0]  inputTerminals
);
    logic [15:0] target;

    // Motor speed only follows the command while run is on
    assign target = runReq ? freqReq : 16'h0000;

    // Commands pass on; terminal never toggles on its own in mode 02
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            forwardRunCommand <= 1'b0;
            freqCommand       <= 16'h0000;
            inputTerminals    <= 5'h00;
            outputFreq        <= 16'h0000;
        end else begin
            forwardRunCommand <= runReq;
            freqCommand       <= freqReq;
            inputTerminals    <= termReq;
            // Slew of 0.5 Hz a cycle keeps ramps short but not instant
            if (outputFreq + 16'h0032 <= target)
                outputFreq <= outputFreq + 16'h0032;
            else if (outputFreq >= target + 16'h0032)
                outputFreq <= outputFreq - 16'h0032;
            else
                outputFreq <= target;
        end
    end
endmodule // dcbs_ctrl_model
`default_nettype wire

// >>> dcbs_monitor.sv
// Port-level assertions for the brake sequencer
`timescale 1ns/1ps
`default_nettype none
`include "dcbs_regs.vh"
module dcbs_monitor #(
    parameter TICK_CYC = 10
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [15:0] regRdata,
    input wire logic [4:0]  inputTerminals,
    input wire logic        forwardRunCommand,
    input wire logic [15:0] freqCommand,
    input wire logic [15:0] outputFreq,
    input wire logic [7:0]  brakeCurrent,
    input wire logic        outputCut,
    input wire logic        brakeActive,
    input wire logic [7:0]  carrierKhz,
    input wire logic        carrierBrakeSel,
    input wire logic        motorSetSecond
);
    logic [1:0]  enMode_q;
    logic        detLevel_q;
    logic [15:0] brkFreq_q;
    logic        waitNz_q;
    logic [7:0]  termFn_q;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // Shadow of written settings; only settled settings are trusted
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enMode_q   <= `DCBS_EN_OFF;
            detLevel_q <= 1'b0;
            brkFreq_q  <= `DCBS_RST_FREQ;
            waitNz_q   <= 1'b0;
            termFn_q   <= `DCBS_RST_TERMFN;
        end else if (regWr) begin
            if (regAddr == `DCBS_ADDR_MODE) begin
                enMode_q   <= (regWdata[1:0] == 2'h3) ? 2'h0 : regWdata[1:0];
                detLevel_q <= regWdata[2];
            end
            if (regAddr == `DCBS_ADDR_FREQ)
                brkFreq_q <= (regWdata > 16'h1770) ? 16'h1770 : regWdata;
            if (regAddr == `DCBS_ADDR_WAIT)
                waitNz_q <= (regWdata[7:0] != 8'h00);
            if (regAddr == `DCBS_ADDR_TERMFN)
                termFn_q <= regWdata[7:0];
        end
    end

    a_carrier_brake: assert property (brakeActive |-> carrierBrakeSel)
        else $error("braking without braking carrier");
    a_carrier_range: assert property (carrierBrakeSel |->
        carrierKhz >= 8'h02 && carrierKhz <= 8'h0F)
        else $error("braking carrier out of range");
    a_read_window: assert property (regRdata != 16'h0000 |-> $past(regRd))
        else $error("read data outside its cycle");
    a_set_stopped: assert property ($changed(motorSetSecond) |->
        $past(outputCut) && !$past(brakeActive))
        else $error("motor set swapped while running");
    a_off_quiet: assert property (enMode_q == 2'h0 &&
        termFn_q != `DCBS_FN_BRAKE |-> !brakeActive)
        else $error("braking with braking disabled");
    a_freq_entry: assert property (enMode_q == 2'h2 && $rose(brakeActive) |->
        $past(forwardRunCommand) && $past(freqCommand) <= brkFreq_q &&
        $past(outputFreq) <= brkFreq_q)
        else $error("frequency brake entered wrongly");
    a_freq_release: assert property (enMode_q == 2'h2 && brakeActive &&
        forwardRunCommand && freqCommand >= brkFreq_q + 16'h00C8 |=>
        !brakeActive)
        else $error("frequency brake kept past hysteresis");
    a_edge_hold: assert property (!detLevel_q && enMode_q == 2'h1 &&
        brakeActive && $rose(forwardRunCommand) |=> brakeActive)
        else $error("edge mode brake cut by command");
    a_coast_first: assert property (waitNz_q && $rose(brakeActive) &&
        !$past(forwardRunCommand) |-> $past(outputCut, 5))
        else $error("braking without coast interval");

    c_freq_brake: cover property (enMode_q == 2'h2 && $rose(brakeActive));
    c_set_swap: cover property ($rose(motorSetSecond));
    c_level_end: cover property (detLevel_q && $fell(brakeActive));
endmodule // dcbs_monitor

bind dcbs_sequencer dcbs_monitor #(.TICK_CYC(TICK_CYC)) u_mon (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .inputTerminals(inputTerminals), .forwardRunCommand(forwardRunCommand),
    .freqCommand(freqCommand), .outputFreq(outputFreq),
    .brakeCurrent(brakeCurrent), .outputCut(outputCut),
    .brakeActive(brakeActive), .carrierKhz(carrierKhz),
    .carrierBrakeSel(carrierBrakeSel), .motorSetSecond(motorSetSecond));
`default_nettype wire

// >>> dcbs_regs.vh
// Register offsets, fields, reset values and timing counts of the brake sequencer
`ifndef DCBS_REGS_VH
`define DCBS_REGS_VH
// Register word addresses
`define DCBS_ADDR_MODE      4'h0
`define DCBS_ADDR_FREQ      4'h1
`define DCBS_ADDR_WAIT      4'h2
`define DCBS_ADDR_DFORCE    4'h3
`define DCBS_ADDR_DTIME     4'h4
`define DCBS_ADDR_SFORCE    4'h5
`define DCBS_ADDR_STIME     4'h6
`define DCBS_ADDR_CARRIER   4'h7
`define DCBS_ADDR_TERMFN    4'h8
`define DCBS_ADDR_STATUS    4'h9
// Mode register fields
`define DCBS_MODE_EN_LSB    0
`define DCBS_MODE_DET_BIT   2
// Brake enable codes
`define DCBS_EN_OFF         2'h0
`define DCBS_EN_ON          2'h1
`define DCBS_EN_FREQ        2'h2
// Terminal function codes
`define DCBS_FN_BRAKE       8'h07
`define DCBS_FN_MSET        8'h08
// Reset values
`define DCBS_RST_MODE       3'h0
`define DCBS_RST_FREQ       16'h0032
`define DCBS_RST_WAIT       8'h00
`define DCBS_RST_FORCE      8'h00
`define DCBS_RST_TIME       8'h05
`define DCBS_RST_CARRIER    8'h05
`define DCBS_RST_TERMFN     8'h00
// Limits: frequency in 0.01 Hz, times in 0.1 s, force in percent
`define DCBS_FREQ_MAX       16'h1770
`define DCBS_HYST           16'h00C8
`define DCBS_WAIT_MAX       8'h32
`define DCBS_TIME_MAX       8'h64
`define DCBS_FORCE_MAX      8'h64
`define DCBS_CAR_MIN        8'h02
`define DCBS_CAR_MAX        8'h0F
// Tick of 0.1 s in ms, derived to 25 MHz cycles
`define DCBS_TICK_MS        100
`define DCBS_CLK_KHZ        25000
`define DCBS_TICK_CYC       (`DCBS_TICK_MS * `DCBS_CLK_KHZ)
`endif

// >>> dcbs_sequencer.v
// DC brake sequencer with motor set select and register port
// Behaviour
// - Function 08 terminal selects second motor set
// - Motor set swaps only while output stopped
// - Enable 00 off, 01 on, 02 frequency
// - Brake when output frequency reaches brake frequency
// - Nonzero wait coasts, then injects current
// - Current scales 0-100 percent, start/decel forces
// - Decel brake time 0-10 s, edge/internal
// - Detect setting 00 edge, 01 level
// - Start braking on start, any detect mode
// - Braking carrier setting 2 to 15 kHz
// - Function 07 terminal brakes directly, enable 00/01
// - External braking uses deceleration force
// - Run off, reach frequency, coast, brake
// - Edge mode brake time beats commands
// - Level mode start command ends braking, except terminal-driven braking
// - Mode 02 brakes with run on, both low
// - Mode 02 ends at brake frequency plus 2Hz
// - Mode 02 start above frequency runs normal
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dcbs_regs.vh"
module dcbs_sequencer #(
    parameter TICK_CYC = `DCBS_TICK_CYC
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire [3:0]  regAddr,
    input  wire [15:0] regWdata,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [15:0] regRdata,
    input  wire [4:0]  inputTerminals,
    input  wire        forwardRunCommand,
    input  wire [15:0] freqCommand,
    input  wire [15:0] outputFreq,
    output reg  [7:0]  brakeCurrent,
    output reg         outputCut,
    output reg         brakeActive,
    output reg  [7:0]  carrierKhz,
    output reg         carrierBrakeSel,
    output reg         motorSetSecond
);
    // Phase encodings
    localparam [2:0] ST_RUN   = 3'h0;
    localparam [2:0] ST_STOP  = 3'h1;
    localparam [2:0] ST_COAST = 3'h2;
    localparam [2:0] ST_BRAKE = 3'h3;
    localparam [2:0] ST_START = 3'h4;
    localparam [2:0] ST_FBRK  = 3'h5;

    // Settings, phase and edge history
    reg [2:0]  modeQ_q;
    reg [15:0] brakeFreq_q;
    reg [7:0]  waitTime_q;
    reg [7:0]  decelForce_q;
    reg [7:0]  decelTime_q;
    reg [7:0]  startForce_q;
    reg [7:0]  startTime_q;
    reg [7:0]  carrier_q;
    reg [7:0]  termFn_q;
    reg [2:0]  state_q;
    reg [2:0]  state_d;
    reg        extBrake_q;
    reg        run_q;
    reg        extDriven_q;

    wire [1:0] enMode = modeQ_q[`DCBS_MODE_EN_LSB +: 2];
    wire       levelMode = modeQ_q[`DCBS_MODE_DET_BIT];

    // Clamp a value to an upper limit
    function [7:0] clamp8;
        input [7:0] v;
        input [7:0] hi;
        begin
            clamp8 = (v > hi) ? hi : v;
        end
    endfunction

    // Percent of rated current, 255 full scale
    function [7:0] scaleForce;
        input [7:0] pct;
        reg   [15:0] p;
        begin
            p = ({8'h00, pct} * 16'd255) / 16'd100;
            scaleForce = p[7:0];
        end
    endfunction

    // Any terminal carrying a function code and held on
    function termOn;
        input [7:0] fn;
        input [7:0] code;
        input [4:0] pins;
        begin
            termOn = (fn == code) ? |pins : 1'b0;
        end
    endfunction

    wire brakePin = termOn(termFn_q, `DCBS_FN_BRAKE, inputTerminals);
    wire setPin   = termOn(termFn_q, `DCBS_FN_MSET, inputTerminals);
    wire extOk    = (enMode == `DCBS_EN_OFF) || (enMode == `DCBS_EN_ON);
    wire extOn    = brakePin && extOk;
    wire extRise  = extOn && !extBrake_q;
    wire runRise  = forwardRunCommand && !run_q;
    wire outLow   = outputFreq <= brakeFreq_q;
    wire cmdLow   = freqCommand <= brakeFreq_q;
    wire cmdHigh  = freqCommand >= brakeFreq_q + `DCBS_HYST;
    wire inFreqMd = (enMode == `DCBS_EN_FREQ);
    wire intOn    = (enMode == `DCBS_EN_ON);

    // Timer control
    reg        tmrLoad;
    reg [7:0]  tmrVal;
    wire       tick;
    wire       tmrDone;

    dcbs_tick #(.TICK_CYC(TICK_CYC)) uTick (
        .mclk    (mclk),
        .rst     (rst),
        .restart (tmrLoad),
        .tick    (tick)
    );

    dcbs_timer uTimer (
        .mclk    (mclk),
        .rst     (rst),
        .load    (tmrLoad),
        .loadVal (tmrVal),
        .tick    (tick),
        .done    (tmrDone)
    );

    // Register writes, settings clamped to their legal ranges, mode enable 3 stored as 00, terminal function as written
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            modeQ_q      <= `DCBS_RST_MODE;
            brakeFreq_q  <= `DCBS_RST_FREQ;
            waitTime_q   <= `DCBS_RST_WAIT;
            decelForce_q <= `DCBS_RST_FORCE;
            decelTime_q  <= `DCBS_RST_TIME;
            startForce_q <= `DCBS_RST_FORCE;
            startTime_q  <= `DCBS_RST_TIME;
            carrier_q    <= `DCBS_RST_CARRIER;
            termFn_q     <= `DCBS_RST_TERMFN;
        end else if (regWr) begin
            case (regAddr)
                `DCBS_ADDR_MODE:
                    modeQ_q <= (regWdata[1:0] == 2'h3) ?
                               {regWdata[2], 2'h0} : regWdata[2:0];
                `DCBS_ADDR_FREQ:
                    brakeFreq_q <= (regWdata > `DCBS_FREQ_MAX) ?
                                   `DCBS_FREQ_MAX : regWdata;
                `DCBS_ADDR_WAIT:
                    waitTime_q <= clamp8(regWdata[7:0], `DCBS_WAIT_MAX);
                `DCBS_ADDR_DFORCE:
                    decelForce_q <= clamp8(regWdata[7:0],
                                           `DCBS_FORCE_MAX);
                `DCBS_ADDR_DTIME:
                    decelTime_q <= clamp8(regWdata[7:0], `DCBS_TIME_MAX);
                `DCBS_ADDR_SFORCE:
                    startForce_q <= clamp8(regWdata[7:0],
                                           `DCBS_FORCE_MAX);
                `DCBS_ADDR_STIME:
                    startTime_q <= clamp8(regWdata[7:0], `DCBS_TIME_MAX);
                `DCBS_ADDR_CARRIER:
                    carrier_q <= (regWdata[7:0] < `DCBS_CAR_MIN) ?
                                 `DCBS_CAR_MIN :
                                 clamp8(regWdata[7:0], `DCBS_CAR_MAX);
                `DCBS_ADDR_TERMFN:
                    termFn_q <= regWdata[7:0];
                default: ;
            endcase
        end
    end

    // Read port, data valid the cycle after the strobe
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                `DCBS_ADDR_MODE:    regRdata <= {13'h0000, modeQ_q};
                `DCBS_ADDR_FREQ:    regRdata <= brakeFreq_q;
                `DCBS_ADDR_WAIT:    regRdata <= {8'h00, waitTime_q};
                `DCBS_ADDR_DFORCE:  regRdata <= {8'h00, decelForce_q};
                `DCBS_ADDR_DTIME:   regRdata <= {8'h00, decelTime_q};
                `DCBS_ADDR_SFORCE:  regRdata <= {8'h00, startForce_q};
                `DCBS_ADDR_STIME:   regRdata <= {8'h00, startTime_q};
                `DCBS_ADDR_CARRIER: regRdata <= {8'h00, carrier_q};
                `DCBS_ADDR_TERMFN:  regRdata <= {8'h00, termFn_q};
                `DCBS_ADDR_STATUS:
                    regRdata <= {10'h000, motorSetSecond, extDriven_q,
                                 1'b0, state_q};
                default:            regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end

    // Phase sequencing; timer loads on entry to the coast, brake and start phases
    always @* begin
        state_d = state_q;
        tmrLoad = 1'b0;
        tmrVal  = 8'h00;
        case (state_q)
            ST_STOP: begin
                if (inFreqMd) begin
                    if (forwardRunCommand && cmdLow && outLow)
                        state_d = ST_FBRK;
                    else if (forwardRunCommand)
                        state_d = ST_RUN;
                end else if (extOn && (levelMode || extRise)) begin
                    state_d = (waitTime_q != 8'h00) ? ST_COAST : ST_BRAKE;
                    tmrLoad = 1'b1;
                    tmrVal  = (waitTime_q != 8'h00) ? waitTime_q
                                                    : decelTime_q;
                end else if (runRise && intOn && startTime_q != 8'h00) begin
                    state_d = ST_START;
                    tmrLoad = 1'b1;
                    tmrVal  = startTime_q;
                end else if (forwardRunCommand) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (inFreqMd) begin
                    if (!forwardRunCommand)
                        state_d = ST_STOP;
                    else if (cmdLow && outLow)
                        state_d = ST_FBRK;
                end else if ((extOn && (levelMode || extRise)) ||
                             (intOn && !forwardRunCommand && outLow)) begin
                    state_d = (waitTime_q != 8'h00) ? ST_COAST : ST_BRAKE;
                    tmrLoad = 1'b1;
                    tmrVal  = (waitTime_q != 8'h00) ? waitTime_q
                                                    : decelTime_q;
                end else if (!forwardRunCommand && !intOn) begin
                    state_d = ST_STOP;
                end
            end
            ST_COAST: begin
                if (tmrDone) begin
                    state_d = ST_BRAKE;
                    tmrLoad = 1'b1;
                    tmrVal  = decelTime_q;
                end
            end
            ST_BRAKE: begin
                if (levelMode && extDriven_q) begin
                    if (!extOn)
                        state_d = forwardRunCommand ? ST_RUN : ST_STOP;
                end else if (levelMode && runRise) begin
                    state_d = ST_RUN;
                end else if (tmrDone) begin
                    state_d = forwardRunCommand ? ST_RUN : ST_STOP;
                end
            end
            ST_START: begin
                if (levelMode && !forwardRunCommand)
                    state_d = ST_STOP;
                else if (tmrDone)
                    state_d = forwardRunCommand ? ST_RUN : ST_STOP;
            end
            ST_FBRK: begin
                if (!forwardRunCommand || !inFreqMd)
                    state_d = ST_STOP;
                else if (cmdHigh)
                    state_d = ST_RUN;
            end
            default: state_d = ST_STOP;
        endcase
    end

    // Phase register and edge history
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q     <= ST_STOP;
            extBrake_q  <= 1'b0;
            run_q       <= 1'b0;
            extDriven_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            extBrake_q <= extOn;
            run_q      <= forwardRunCommand;
            // Remember whether the terminal started this brake phase
            if (state_d == ST_STOP || state_d == ST_RUN)
                extDriven_q <= 1'b0;
            else if ((state_q == ST_STOP || state_q == ST_RUN) && extOn)
                extDriven_q <= 1'b1;
        end
    end

    // Outputs registered from the next phase, carrier from its setting, motor set from the current phase
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            brakeCurrent    <= 8'h00;
            outputCut       <= 1'b1;
            brakeActive     <= 1'b0;
            carrierKhz      <= `DCBS_RST_CARRIER;
            carrierBrakeSel <= 1'b0;
            motorSetSecond  <= 1'b0;
        end else begin
            case (state_d)
                ST_START:
                    brakeCurrent <= scaleForce(startForce_q);
                ST_BRAKE, ST_FBRK:
                    brakeCurrent <= scaleForce(decelForce_q);
                default:
                    brakeCurrent <= 8'h00;
            endcase
            outputCut   <= (state_d == ST_COAST) || (state_d == ST_STOP);
            brakeActive <= (state_d == ST_BRAKE) || (state_d == ST_START) ||
                           (state_d == ST_FBRK);
            carrierBrakeSel <= (state_d == ST_BRAKE) ||
                               (state_d == ST_START) ||
                               (state_d == ST_FBRK);
            carrierKhz  <= carrier_q;
            // Swapping sets while driving would upset the motor model
            if (state_q == ST_STOP)
                motorSetSecond <= setPin;
        end
    end
endmodule // dcbs_sequencer
`default_nettype wire

// >>> dcbs_tick.v
// Divider giving a one-cycle 0.1 s enable pulse
`timescale 1ns/1ps
`default_nettype none
`include "dcbs_regs.vh"
module dcbs_tick #(
    parameter TICK_CYC = `DCBS_TICK_CYC
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        restart,
    output reg         tick
);
    reg [21:0] cnt_q;

    // Restart aligns the first tick to a full period after a phase change
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= 22'h000000;
            tick  <= 1'b0;
        end else if (restart) begin
            cnt_q <= 22'h000000;
            tick  <= 1'b0;
        end else if (cnt_q == TICK_CYC - 1) begin
            cnt_q <= 22'h000000;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 22'h000001;
            tick  <= 1'b0;
        end
    end
endmodule // dcbs_tick
`default_nettype wire

// >>> dcbs_timer.v
// Down counter of 0.1 s units, reports expiry
`timescale 1ns/1ps
`default_nettype none
module dcbs_timer (
    input  wire        mclk,
    input  wire        rst,
    input  wire        load,
    input  wire [7:0]  loadVal,
    input  wire        tick,
    output wire        done
);
    reg [7:0] cnt_q;

    // Load wins over counting so a phase always starts full
    always @(posedge mclk or posedge rst) begin
        if (rst)
            cnt_q <= 8'h00;
        else if (load)
            cnt_q <= loadVal;
        else if (tick && cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
    end

    assign done = (cnt_q == 8'h00);
endmodule // dcbs_timer
`default_nettype wire
